//--- instruction_format_consts.svh
// constants for the instruction format decoder
`ifndef INSTRUCTION_FORMAT_CONSTS_SVH
`define INSTRUCTION_FORMAT_CONSTS_SVH

// ---------------------------------------------
// prefix bytes and pages
// ---------------------------------------------
`define PREFIX_PAGE1 8'h17
`define PREFIX_PAGE2 8'h27
`define PREFIX_PAGE3 8'h37
`define PAGE0 2'h0
`define PAGES_TOTAL 4
`define OPCODES_PER_PAGE 256

// ---------------------------------------------
// word fields
// ---------------------------------------------
`define HI_BYTE_MSB 15
`define HI_BYTE_LSB 8
`define LO_BYTE_MSB 7
`define LO_BYTE_LSB 0
`define NIB_X_MSB 7
`define NIB_X_LSB 4
`define NIB_Y_MSB 3
`define NIB_Y_LSB 0

// ---------------------------------------------
// sizes and offsets
// ---------------------------------------------
`define MAX_INSTR_BYTES 6
`define MAX_INSTR_WORDS 2'd3
`define PREFETCH_OFFSET 20'h00006
`define XFER_ADJUST 20'h00002
`define SUB_FRAME_WORDS 2'd2
`define IDLE_FRAME_WORDS 2'd3
`define ADDR_RESET 20'h00000

// ---------------------------------------------
// opcode assignments
// ---------------------------------------------
`define OPC_S2X 10'h24f
`define OPC_S2Y 10'h25f
`define OPC_X2S 10'h24e
`define OPC_Y2S 10'h25e
`define OPC_X2Y 10'h24c
`define OPC_Y2X 10'h25c
`define OPC_RET_INT 10'h277
`define OPC_RET_SUB 10'h2f7
`define OPC_IDLE 10'h127
`define OPC_JMP_INDEXED_20BIT_OFFSET_MODE 10'h04b
`define OPC_JMP_EXTENDED_20BIT_MODE 10'h07a
`define OPC_CALL_INDEXED_20BIT_OFFSET_MODE 10'h089
`define OPC_CALL_EXTENDED_20BIT_MODE 10'h0fa
`define OPC_THREE_WORD 10'h337

`endif

//--- instruction_format_pkg.sv
// types shared by the instruction format decoder
package instruction_format_pkg;

  typedef enum logic [2:0] {
    ST_FIRST = 3'b001,
    ST_MORE = 3'b010,
    ST_DONE = 3'b100
  } dec_state_e;

  typedef enum logic [2:0] {
    XFER_NONE = 3'h0,
    XFER_S2X = 3'h1,
    XFER_S2Y = 3'h2,
    XFER_X2S = 3'h3,
    XFER_Y2S = 3'h4,
    XFER_X2Y = 3'h5,
    XFER_Y2X = 3'h6
  } xfer_op_e;

endpackage

//--- register_transfer_unit.sv
// stack and index register transfer arithmetic
`timescale 1ns/1ps
`include "instruction_format_consts.svh"

module register_transfer_unit (
  // operation
  input wire instruction_format_pkg::xfer_op_e op,
  // source registers
  input wire logic [3:0] stack_bank,
  input wire logic [15:0] stack_pointer,
  input wire logic [3:0] index_x_bank,
  input wire logic [15:0] index_x,
  input wire logic [3:0] index_y_bank,
  input wire logic [15:0] index_y,
  // result, bank in bits 19:16
  output logic [19:0] result,
  output logic wr_stack,
  output logic wr_index_x,
  output logic wr_index_y
);

  logic [19:0] stack_cat;
  logic [19:0] x_cat;
  logic [19:0] y_cat;

  assign stack_cat = {stack_bank, stack_pointer};
  assign x_cat = {index_x_bank, index_x};
  assign y_cat = {index_y_bank, index_y};

  always_comb begin
    result = 20'h00000;
    wr_stack = 1'b0;
    wr_index_x = 1'b0;
    wr_index_y = 1'b0;
    case (op)
      // [RQ8] stack plus two
      instruction_format_pkg::XFER_S2X: begin
        result = stack_cat + `XFER_ADJUST;
        wr_index_x = 1'b1;
      end
      instruction_format_pkg::XFER_S2Y: begin
        result = stack_cat + `XFER_ADJUST;
        wr_index_y = 1'b1;
      end
      // [RQ9] index minus two
      instruction_format_pkg::XFER_X2S: begin
        result = x_cat - `XFER_ADJUST;
        wr_stack = 1'b1;
      end
      instruction_format_pkg::XFER_Y2S: begin
        result = y_cat - `XFER_ADJUST;
        wr_stack = 1'b1;
      end
      // [RQ10] bank field travels too
      instruction_format_pkg::XFER_X2Y: begin
        result = x_cat;
        wr_index_y = 1'b1;
      end
      instruction_format_pkg::XFER_Y2X: begin
        result = y_cat;
        wr_index_x = 1'b1;
      end
      default: begin
        result = 20'h00000;
      end
    endcase
  end

endmodule

//--- instruction_format_decoder.sv
// instruction word splitter and transfer/return/idle control
//
// What this block does
// [RQ1] optional prefix, one opcode, then operands
// [RQ2] four 256-opcode pages; unprefixed is page 0
// [RQ3] prefixes 17, 27, 37 select pages 1-3
// [RQ4] 4/8/16-bit operands; nibbles zero-extended or paired
// [RQ5] fetch even-address words; even instruction lengths
// [RQ6] at most three words per instruction
// [RQ7] page-0 opcode and byte operand share word
// [RQ8] stack-to-index copies add two first
// [RQ9] index-to-stack copies subtract two first
// [RQ10] index-to-index copies carry bank field
// [RQ11] interrupt return restores counter and flags only
// [RQ12] subroutine return pops two-word frame
// [RQ13] idle stacks frame, waits for interrupt/reset
// [RQ14] jump/call use 20-bit indexed and extended
// [RQ15] opcode decode fixes operand word count
// [RQ16] program counter reads first word plus six
// [RQ17] high byte prefix/opcode, low byte opcode/operand
`timescale 1ns/1ps
`include "instruction_format_consts.svh"

module instruction_format_decoder (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // instruction words from program memory
  input wire logic word_valid,
  input wire logic [15:0] word_data,
  input wire logic [19:0] word_addr,
  output logic word_ready,
  // core register values
  input wire logic [3:0] stack_bank,
  input wire logic [15:0] stack_pointer,
  input wire logic [3:0] index_x_bank,
  input wire logic [15:0] index_x,
  input wire logic [3:0] index_y_bank,
  input wire logic [15:0] index_y,
  // wake sources for the idle state
  input wire logic irq_event,
  // decoded instruction
  output logic instr_valid,
  output logic [1:0] page,
  output logic [7:0] opcode,
  output logic [1:0] instr_words,
  output logic [7:0] operand_byte,
  output logic [7:0] operand_x_nibble,
  output logic [7:0] operand_y_nibble,
  output logic [15:0] operand_word1,
  output logic [15:0] operand_word2,
  output logic [19:0] target_addr20,
  output logic [19:0] program_counter,
  output logic misaligned_fetch,
  // register transfer results
  output logic [19:0] xfer_result,
  output logic wr_stack,
  output logic wr_index_x,
  output logic wr_index_y,
  // stack frame control
  output logic restore_program_counter,
  output logic restore_condition_flags,
  output logic [1:0] pop_words,
  output logic [1:0] push_words,
  output logic idle_active
);

  // ---------------------------------------------
  // word count per opcode
  // ---------------------------------------------
  // [RQ15] size from opcode
  function automatic logic [1:0] words_for(input logic [1:0] pg, input logic [7:0] op);
    logic [9:0] key;
    key = {pg, op};
    case (key)
      // [RQ14] 20-bit jump and call forms
      `OPC_JMP_INDEXED_20BIT_OFFSET_MODE, `OPC_JMP_EXTENDED_20BIT_MODE, `OPC_CALL_INDEXED_20BIT_OFFSET_MODE, `OPC_CALL_EXTENDED_20BIT_MODE: words_for = 2'd2;
      // [RQ6] longest form is three words
      `OPC_THREE_WORD: words_for = `MAX_INSTR_WORDS;
      default: words_for = 2'd1;
    endcase
  endfunction

  function automatic instruction_format_pkg::xfer_op_e xfer_for(input logic [9:0] key);
    case (key)
      `OPC_S2X: xfer_for = instruction_format_pkg::XFER_S2X;
      `OPC_S2Y: xfer_for = instruction_format_pkg::XFER_S2Y;
      `OPC_X2S: xfer_for = instruction_format_pkg::XFER_X2S;
      `OPC_Y2S: xfer_for = instruction_format_pkg::XFER_Y2S;
      `OPC_X2Y: xfer_for = instruction_format_pkg::XFER_X2Y;
      `OPC_Y2X: xfer_for = instruction_format_pkg::XFER_Y2X;
      default: xfer_for = instruction_format_pkg::XFER_NONE;
    endcase
  endfunction

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  instruction_format_pkg::dec_state_e state_reg, state_next;
  logic ready_reg, ready_next;
  logic valid_reg, valid_next;
  logic [1:0] page_reg, page_next;
  logic [7:0] opcode_reg, opcode_next;
  logic [1:0] words_reg, words_next;
  logic [1:0] got_reg, got_next;
  logic [15:0] first_reg, first_next;
  logic [15:0] w1_reg, w1_next;
  logic [15:0] w2_reg, w2_next;
  logic [19:0] pc_reg, pc_next;
  logic mis_reg, mis_next;
  logic [19:0] res_reg, res_next;
  logic wr_s_reg, wr_s_next;
  logic wr_x_reg, wr_x_next;
  logic wr_y_reg, wr_y_next;
  logic rpc_reg, rpc_next;
  logic rcf_reg, rcf_next;
  logic [1:0] pop_reg, pop_next;
  logic [1:0] push_reg, push_next;
  logic idle_reg, idle_next;

  logic take;
  logic is_prefix;
  logic [1:0] cur_page;
  logic [7:0] cur_op;
  logic [9:0] done_key;
  logic [19:0] ru_result;
  logic ru_s, ru_x, ru_y;
  instruction_format_pkg::xfer_op_e done_xfer;

  assign take = word_valid & ready_reg;
  // [RQ17] high byte holds prefix or opcode
  assign is_prefix = (word_data[`HI_BYTE_MSB:`HI_BYTE_LSB] == `PREFIX_PAGE1) ||
                     (word_data[`HI_BYTE_MSB:`HI_BYTE_LSB] == `PREFIX_PAGE2) ||
                     (word_data[`HI_BYTE_MSB:`HI_BYTE_LSB] == `PREFIX_PAGE3);
  // [RQ3] prefix bits 5:4 give the page
  assign cur_page = is_prefix ? word_data[13:12] : `PAGE0;
  // [RQ2] page 0 opcode stands alone
  assign cur_op = is_prefix ? word_data[`LO_BYTE_MSB:`LO_BYTE_LSB]
                            : word_data[`HI_BYTE_MSB:`HI_BYTE_LSB];
  assign done_key = state_reg[1] ? {page_reg, opcode_reg} : {cur_page, cur_op};
  assign done_xfer = xfer_for(done_key);

  register_transfer_unit u_xfer (
    .op(done_xfer),
    .stack_bank(stack_bank),
    .stack_pointer(stack_pointer),
    .index_x_bank(index_x_bank),
    .index_x(index_x),
    .index_y_bank(index_y_bank),
    .index_y(index_y),
    .result(ru_result),
    .wr_stack(ru_s),
    .wr_index_x(ru_x),
    .wr_index_y(ru_y)
  );

  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  always_comb begin
    logic finish;
    finish = 1'b0;
    state_next = state_reg;
    page_next = page_reg;
    opcode_next = opcode_reg;
    words_next = words_reg;
    got_next = got_reg;
    first_next = first_reg;
    w1_next = w1_reg;
    w2_next = w2_reg;
    pc_next = pc_reg;
    mis_next = 1'b0;
    idle_next = idle_reg;
    case (state_reg)
      // [RQ1] first word: prefix+opcode or opcode+operand
      instruction_format_pkg::ST_FIRST: begin
        if (take) begin
          page_next = cur_page;
          opcode_next = cur_op;
          first_next = word_data;
          words_next = words_for(cur_page, cur_op);
          got_next = 2'd1;
          w1_next = 16'h0000;
          w2_next = 16'h0000;
          // [RQ16] prefetch leaves counter six bytes ahead
          pc_next = word_addr + `PREFETCH_OFFSET;
          // [RQ5] odd address is flagged
          mis_next = word_addr[0];
          if (words_for(cur_page, cur_op) == 2'd1) begin
            finish = 1'b1;
            state_next = instruction_format_pkg::ST_DONE;
          end else begin
            state_next = instruction_format_pkg::ST_MORE;
          end
        end
      end
      // [RQ6] gather no more than counted
      instruction_format_pkg::ST_MORE: begin
        if (take) begin
          mis_next = word_addr[0];
          if (got_reg == 2'd1) begin
            w1_next = word_data;
          end else begin
            w2_next = word_data;
          end
          got_next = got_reg + 2'd1;
          if (got_reg + 2'd1 >= words_reg) begin
            finish = 1'b1;
            state_next = instruction_format_pkg::ST_DONE;
          end
        end
      end
      instruction_format_pkg::ST_DONE: begin
        state_next = instruction_format_pkg::ST_FIRST;
      end
      default: begin
        state_next = instruction_format_pkg::ST_FIRST;
      end
    endcase

    valid_next = finish;
    res_next = finish ? ru_result : res_reg;
    wr_s_next = finish & ru_s;
    wr_x_next = finish & ru_x;
    wr_y_next = finish & ru_y;
    // [RQ11] only counter and flags come back
    rpc_next = finish & (done_key == `OPC_RET_INT);
    rcf_next = finish & (done_key == `OPC_RET_INT);
    // [RQ12] two-word return frame
    pop_next = (finish && (done_key == `OPC_RET_SUB)) ? `SUB_FRAME_WORDS : 2'd0;
    push_next = 2'd0;
    if (finish) begin
      // [RQ14] call builds matching frame
      if ((done_key == `OPC_CALL_INDEXED_20BIT_OFFSET_MODE) || (done_key == `OPC_CALL_EXTENDED_20BIT_MODE)) begin
        push_next = `SUB_FRAME_WORDS;
      end
      // [RQ13] idle stacks its frame then halts
      if (done_key == `OPC_IDLE) begin
        push_next = `IDLE_FRAME_WORDS;
        idle_next = 1'b1;
      end
    end
    // [RQ13] only an interrupt or reset ends the wait; no timeout
    if (idle_reg && irq_event) begin
      idle_next = 1'b0;
    end
    // suspended while idle; stall during the done beat keeps one word per step
    ready_next = (state_next != instruction_format_pkg::ST_DONE) && !idle_next;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= instruction_format_pkg::ST_FIRST;
      ready_reg <= 1'b0;
      valid_reg <= 1'b0;
      page_reg <= 2'h0;
      opcode_reg <= 8'h00;
      words_reg <= 2'h1;
      got_reg <= 2'h0;
      first_reg <= 16'h0000;
      w1_reg <= 16'h0000;
      w2_reg <= 16'h0000;
      pc_reg <= `ADDR_RESET;
      mis_reg <= 1'b0;
      res_reg <= 20'h00000;
      wr_s_reg <= 1'b0;
      wr_x_reg <= 1'b0;
      wr_y_reg <= 1'b0;
      rpc_reg <= 1'b0;
      rcf_reg <= 1'b0;
      pop_reg <= 2'h0;
      push_reg <= 2'h0;
      idle_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ready_reg <= ready_next;
      valid_reg <= valid_next;
      page_reg <= page_next;
      opcode_reg <= opcode_next;
      words_reg <= words_next;
      got_reg <= got_next;
      first_reg <= first_next;
      w1_reg <= w1_next;
      w2_reg <= w2_next;
      pc_reg <= pc_next;
      mis_reg <= mis_next;
      res_reg <= res_next;
      wr_s_reg <= wr_s_next;
      wr_x_reg <= wr_x_next;
      wr_y_reg <= wr_y_next;
      rpc_reg <= rpc_next;
      rcf_reg <= rcf_next;
      pop_reg <= pop_next;
      push_reg <= push_next;
      idle_reg <= idle_next;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign word_ready = ready_reg;
  assign instr_valid = valid_reg;
  assign page = page_reg;
  assign opcode = opcode_reg;
  assign instr_words = words_reg;
  // [RQ7] byte operand rides in the opcode word
  assign operand_byte = first_reg[`LO_BYTE_MSB:`LO_BYTE_LSB];
  // [RQ4] nibbles zero-extended, two per byte
  assign operand_x_nibble = {4'h0, first_reg[`NIB_X_MSB:`NIB_X_LSB]};
  assign operand_y_nibble = {4'h0, first_reg[`NIB_Y_MSB:`NIB_Y_LSB]};
  assign operand_word1 = w1_reg;
  assign operand_word2 = w2_reg;
  // [RQ14] extension nibble over next word
  assign target_addr20 = {first_reg[`NIB_Y_MSB:`NIB_Y_LSB], w1_reg};
  assign program_counter = pc_reg;
  assign misaligned_fetch = mis_reg;
  assign xfer_result = res_reg;
  assign wr_stack = wr_s_reg;
  assign wr_index_x = wr_x_reg;
  assign wr_index_y = wr_y_reg;
  assign restore_program_counter = rpc_reg;
  assign restore_condition_flags = rcf_reg;
  assign pop_words = pop_reg;
  assign push_words = push_reg;
  assign idle_active = idle_reg;

endmodule

//--- program_memory_model.sv
// program memory model that hands instruction words to the decoder
`timescale 1ns/1ps
module program_memory_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // word bus
  input wire logic word_ready,
  output logic word_valid,
  output logic [15:0] word_data,
  output logic [19:0] word_addr
);
  // ---------------------------------------------
  // word queue; bit 16 asks for an odd address
  // ---------------------------------------------
  logic [16:0] words_q[$];
  logic [19:0] next_addr;
  logic [19:0] addr_now;
  logic took;
  bit slow = 1'b0;
  task automatic put(input logic [16:0] w);
    words_q.push_back(w);
  endtask
  assign took = word_valid && word_ready;
  assign addr_now = took ? next_addr + 20'h00002 : next_addr;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      word_valid <= 1'b0;
      word_data <= 16'h0000;
      word_addr <= 20'h00000;
      next_addr <= 20'h00000;
    end else begin
      if (took) begin
        void'(words_q.pop_front());
        next_addr <= addr_now;
      end
      // a slow memory leaves one idle cycle after each taken word
      if (words_q.size() != 0 && !(took && slow)) begin
        word_valid <= 1'b1;
        word_data <= words_q[0][15:0];
        word_addr <= addr_now | {19'h00000, words_q[0][16]};
      end else begin
        // a released bus flips, so a stale word never looks valid
        word_valid <= 1'b0;
        word_data <= ~word_data;
      end
    end
  end
endmodule

//--- instruction_format_decoder_sva.sv
// port assertions for the instruction format decoder
`timescale 1ns/1ps
`include "instruction_format_consts.svh"
module instruction_format_decoder_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // word bus and core inputs
  input wire logic word_valid,
  input wire logic [15:0] word_data,
  input wire logic [19:0] word_addr,
  input wire logic word_ready,
  input wire logic [3:0] stack_bank,
  input wire logic [15:0] stack_pointer,
  input wire logic irq_event,
  // decoded outputs
  input wire logic instr_valid,
  input wire logic [1:0] page,
  input wire logic [7:0] opcode,
  input wire logic [1:0] instr_words,
  input wire logic [19:0] program_counter,
  input wire logic misaligned_fetch,
  input wire logic [19:0] xfer_result,
  input wire logic wr_index_x,
  input wire logic restore_program_counter,
  input wire logic restore_condition_flags,
  input wire logic [1:0] pop_words,
  input wire logic idle_active
);
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic [9:0] op_key;
  logic is_prefix;
  logic take_odd;
  logic [19:0] stack_cat;
  assign op_key = {page, opcode};
  assign take_odd = word_valid && word_ready && word_addr[0];
  assign stack_cat = {stack_bank, stack_pointer};
  assign is_prefix = word_data[15:8] == `PREFIX_PAGE1 || word_data[15:8] == `PREFIX_PAGE2
    || word_data[15:8] == `PREFIX_PAGE3;
  sequence took_one;
    word_valid && word_ready ##1 instr_valid && instr_words == 2'd1;
  endsequence
  sequence wake_up;
    idle_active && irq_event;
  endsequence
  // ---------------------------------------------
  // properties
  // ---------------------------------------------
  pc_offset_a: assert property (took_one |->
    program_counter == $past(word_addr) + `PREFETCH_OFFSET) else $error("bad pc offset");
  page_select_a: assert property (took_one |->
    page == ($past(is_prefix) ? $past(word_data[13:12]) : `PAGE0)) else $error("bad page");
  opcode_pick_a: assert property (took_one |-> opcode ==
    ($past(is_prefix) ? $past(word_data[7:0]) : $past(word_data[15:8]))) else $error("bad opcode");
  done_refuse_a: assert property (instr_valid |-> !word_ready)
    else $error("word taken on done beat");
  misalign_flag_a: assert property (1'b1 |=> misaligned_fetch == $past(take_odd))
    else $error("misaligned flag wrong");
  stack_add_a: assert property (took_one ##0 op_key == `OPC_S2X |-> wr_index_x
    && xfer_result == $past(stack_cat) + `XFER_ADJUST) else $error("stack copy wrong");
  int_return_a: assert property (instr_valid && op_key == `OPC_RET_INT |->
    restore_program_counter && restore_condition_flags && pop_words == 2'd0)
    else $error("interrupt return wrong");
  sub_return_a: assert property (instr_valid && op_key == `OPC_RET_SUB |->
    pop_words == `SUB_FRAME_WORDS && !restore_condition_flags) else $error("return wrong");
  idle_hold_a: assert property (idle_active && !irq_event |=> idle_active && !word_ready)
    else $error("idle left early");
  idle_wake_a: assert property (wake_up |=> !idle_active && word_ready)
    else $error("idle not left");
endmodule
bind instruction_format_decoder instruction_format_decoder_sva chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .word_valid(word_valid), .word_data(word_data),
  .word_addr(word_addr), .word_ready(word_ready), .stack_bank(stack_bank),
  .stack_pointer(stack_pointer), .irq_event(irq_event), .instr_valid(instr_valid),
  .page(page), .opcode(opcode), .instr_words(instr_words), .program_counter(program_counter),
  .misaligned_fetch(misaligned_fetch), .xfer_result(xfer_result), .wr_index_x(wr_index_x),
  .restore_program_counter(restore_program_counter),
  .restore_condition_flags(restore_condition_flags), .pop_words(pop_words),
  .idle_active(idle_active)
);

//--- instruction_format_decoder_tb.sv
// self-checking bench for the instruction format decoder
`timescale 1ns/1ps
`include "instruction_format_consts.svh"
module instruction_format_decoder_tb;
  logic sys_clk, arst_n, word_valid, word_ready, irq_event, instr_valid, misaligned_fetch;
  logic wr_stack, wr_index_x, wr_index_y, restore_program_counter, restore_condition_flags;
  logic idle_active;
  logic [3:0] stack_bank, index_x_bank, index_y_bank;
  logic [15:0] word_data, stack_pointer, index_x, index_y, operand_word1, operand_word2;
  logic [1:0] page, instr_words, pop_words, push_words;
  logic [7:0] opcode, operand_byte, operand_x_nibble, operand_y_nibble;
  logic [19:0] word_addr, target_addr20, program_counter, xfer_result, exp_addr;
  int bad_count = 0;
  int samples_checked = 0;
  program_memory_model mem (.sys_clk(sys_clk), .arst_n(arst_n), .word_ready(word_ready),
    .word_valid(word_valid), .word_data(word_data), .word_addr(word_addr));
  instruction_format_decoder uut (.sys_clk(sys_clk), .arst_n(arst_n),
    .word_valid(word_valid), .word_data(word_data), .word_addr(word_addr),
    .word_ready(word_ready), .stack_bank(stack_bank), .stack_pointer(stack_pointer),
    .index_x_bank(index_x_bank), .index_x(index_x), .index_y_bank(index_y_bank),
    .index_y(index_y), .irq_event(irq_event), .instr_valid(instr_valid), .page(page),
    .opcode(opcode), .instr_words(instr_words), .operand_byte(operand_byte),
    .operand_x_nibble(operand_x_nibble), .operand_y_nibble(operand_y_nibble),
    .operand_word1(operand_word1), .operand_word2(operand_word2),
    .target_addr20(target_addr20), .program_counter(program_counter),
    .misaligned_fetch(misaligned_fetch), .xfer_result(xfer_result), .wr_stack(wr_stack),
    .wr_index_x(wr_index_x), .wr_index_y(wr_index_y),
    .restore_program_counter(restore_program_counter),
    .restore_condition_flags(restore_condition_flags), .pop_words(pop_words),
    .push_words(push_words), .idle_active(idle_active));
  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // first word of an instruction from its page and opcode
  function automatic logic [15:0] fw(input logic [9:0] key, input logic [7:0] lo);
    return (key[9:8] == `PAGE0) ? {key[7:0], lo} : {2'b00, key[9:8], 4'h7, key[7:0]};
  endfunction
  task automatic wait_done(input int n, input logic odd);
    int i;
    i = 0;
    do begin
      @(posedge sys_clk);
      #1;
      i++;
    end while (instr_valid !== 1'b1 && i < 50);
    check(instr_valid, 1'b1);
    check(program_counter, (exp_addr | {19'h00000, odd}) + `PREFETCH_OFFSET);
    exp_addr = exp_addr + 20'(2 * n);
  endtask
  task automatic issue(input logic [15:0] w0, w1, w2, input int n, input logic odd);
    mem.put({odd, w0});
    if (n > 1) mem.put({1'b0, w1});
    if (n > 2) mem.put({1'b0, w2});
    wait_done(n, odd);
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic test_pages;
    int p;
    for (p = 0; p < 4; p++) begin
      issue(fw({p[1:0], 8'h55}, 8'ha3), 16'h0000, 16'h0000, 1, 1'b0);
      check(page, p[1:0]);
      check(opcode, 8'h55);
      check(instr_words, 2'd1);
      check(misaligned_fetch, 1'b0);
    end
    issue(16'h55a3, 16'h0000, 16'h0000, 1, 1'b1);
    check(misaligned_fetch, 1'b1);
    check(operand_byte, 8'ha3);
    check({operand_x_nibble, operand_y_nibble}, 16'h0a03);
    $display("pages done");
  endtask
  task automatic test_transfers;
    logic [9:0] keys [6] = '{`OPC_S2X, `OPC_S2Y, `OPC_X2S, `OPC_Y2S, `OPC_X2Y, `OPC_Y2X};
    logic [19:0] res [6] = '{20'h40001, 20'h40001, 20'h4ffff, 20'h8fffe, 20'h50001, 20'h90000};
    logic [2:0] dest [6] = '{3'b010, 3'b001, 3'b100, 3'b100, 3'b001, 3'b010};
    int k;
    @(posedge sys_clk);
    stack_bank <= 4'h3;
    stack_pointer <= 16'hffff;
    index_x_bank <= 4'h5;
    index_x <= 16'h0001;
    index_y_bank <= 4'h9;
    index_y <= 16'h0000;
    for (k = 0; k < 6; k++) begin
      issue(fw(keys[k], 8'h00), 16'h0000, 16'h0000, 1, 1'b0);
      check(xfer_result, res[k]);
      check({wr_stack, wr_index_x, wr_index_y}, dest[k]);
    end
    $display("transfers done");
  endtask
  task automatic test_returns;
    issue(fw(`OPC_RET_INT, 8'h00), 16'h0000, 16'h0000, 1, 1'b0);
    check({restore_program_counter, restore_condition_flags, pop_words}, 4'b1100);
    check({wr_stack, wr_index_x, wr_index_y}, 3'b000);
    issue(fw(`OPC_RET_SUB, 8'h00), 16'h0000, 16'h0000, 1, 1'b0);
    check({restore_program_counter, restore_condition_flags, pop_words}, 4'b0010);
    $display("returns done");
  endtask
  task automatic test_calls;
    logic [9:0] keys [4] = '{`OPC_JMP_INDEXED_20BIT_OFFSET_MODE, `OPC_JMP_EXTENDED_20BIT_MODE, `OPC_CALL_INDEXED_20BIT_OFFSET_MODE, `OPC_CALL_EXTENDED_20BIT_MODE};
    int k;
    for (k = 0; k < 4; k++) begin
      // odd passes stall the memory between words
      mem.slow = k[0];
      issue(fw(keys[k], 8'h0c), 16'h1234, 16'h0000, 2, 1'b0);
      check(instr_words, 2'd2);
      check(target_addr20, 20'hc1234);
      check(push_words, (k > 1) ? `SUB_FRAME_WORDS : 2'd0);
    end
    mem.slow = 1'b0;
    $display("calls done");
  endtask
  task automatic test_three;
    issue(fw(`OPC_THREE_WORD, 8'h00), 16'haaaa, 16'h5555, 3, 1'b0);
    check(instr_words, `MAX_INSTR_WORDS);
    check({operand_word1, operand_word2}, 32'haaaa5555);
    issue(fw(10'h066, 8'h11), 16'h0000, 16'h0000, 1, 1'b0);
    check({page, opcode, instr_words}, 12'h066 << 2 | 12'h001);
    $display("three words done");
  endtask
  task automatic test_idle;
    issue(fw(`OPC_IDLE, 8'h00), 16'h0000, 16'h0000, 1, 1'b0);
    check(push_words, `IDLE_FRAME_WORDS);
    mem.put({1'b0, fw(10'h066, 8'h22)});
    repeat (6) @(posedge sys_clk);
    #1;
    check({idle_active, word_ready}, 2'b10);
    @(posedge sys_clk);
    irq_event <= 1'b1;
    @(posedge sys_clk);
    irq_event <= 1'b0;
    wait_done(1, 1'b0);
    check(operand_byte, 8'h22);
    $display("idle done");
  endtask
  // ---------------------------------------------
  // run control
  // ---------------------------------------------
  task automatic finish_test;
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // the tests need under a hundred cycles; this is ample margin
  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    finish_test();
  end
  initial begin
    arst_n = 1'b0;
    irq_event = 1'b0;
    stack_bank = 4'h0;
    stack_pointer = 16'h0000;
    index_x_bank = 4'h0;
    index_x = 16'h0000;
    index_y_bank = 4'h0;
    index_y = 16'h0000;
    exp_addr = `ADDR_RESET;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    test_pages();
    test_transfers();
    test_returns();
    test_calls();
    test_three();
    test_idle();
    finish_test();
  end
endmodule
